//--- logic/rlt_top.sv
// Purpose: 16-bit up-counting auto-reload timer with prescaler
// Assumes: Byte register port on ref_clk; isr_enter from the CPU on ref_clk
// Notes:   Overflow pulse doubles as the serial baud clock source
//
// Behaviour
// - Sixteen-bit up counter, reloads instead of wrapping
// - Three-bit select picks divide by 1 to 128
// - Run bit 3 halts or lets counter run
// - Rollover from FFFF sets flag, loads reload
// - Interrupt requested when flag and enable set
// - Entering service routine clears overflow flag
// - Software may set or clear flag bit 4
// - Control and reload bytes read-write, reset zero
// - Overflow offered as baud clock to serial ports
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ns
module rlt_top
  import rlt_pkg::*;
#(
  parameter int CNT_W = rlt_pkg::RLT_CNT_W,
  parameter int PS_W  = rlt_pkg::RLT_PS_W
) (
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               arst_n,
  // Register port
  input  wire rlt_pkg::rlt_addr_t reg_addr,
  input  wire rlt_pkg::rlt_byte_t reg_wr_data,
  input  wire logic               reg_wr_stb,
  input  wire logic               reg_rd_stb,
  output      rlt_pkg::rlt_byte_t reg_rd_data,
  // Processor side
  input  wire logic               isr_enter,
  output      logic               irq,
  // Serial ports
  output      logic               baud_tick
);
  import rlt_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (CNT_W != 2 * RLT_DATA_W) begin : g_bad_cnt
    $error("Counter width must match the two reload bytes");
  end
  if (PS_W != RLT_PS_W) begin : g_bad_ps
    $error("Prescale width must match the control field");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [PS_W-1:0]  ps_q;
  logic             run_q;
  logic             ovf_q;
  logic             ovf_d;
  rlt_byte_t        reload_lo_q;
  rlt_byte_t        reload_hi_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic             misuse_q;
  logic             misuse_d;
  rlt_irq_t         mask_q;
  rlt_byte_t        cnt_hi_snap_q;
  rlt_byte_t        rd_data_q;
  rlt_byte_t        rd_mux;
  logic             irq_q;
  logic             baud_q;
  logic             wr_ctrl;
  logic             wr_rlo;
  logic             wr_rhi;
  logic             wr_stat;
  logic             wr_mask;
  logic             rd_cnt_lo;
  logic             rollover;
  rlt_word_t        reload_w;
  rlt_word_t        cnt_w;
  rlt_byte_t        ctrl_view;
  rlt_byte_t        stat_view;
  rlt_byte_t        mask_view;

  rlt_tick_if #(.PS_W(PS_W)) tk ();

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic reg_hit(input rlt_addr_t a, input rlt_addr_t off);
    return a == off;
  endfunction

  assign wr_ctrl   = reg_wr_stb && reg_hit(reg_addr, RLT_OFF_CTRL);
  assign wr_rlo    = reg_wr_stb && reg_hit(reg_addr, RLT_OFF_RELOAD_LO);
  assign wr_rhi    = reg_wr_stb && reg_hit(reg_addr, RLT_OFF_RELOAD_HI);
  assign wr_stat   = reg_wr_stb && reg_hit(reg_addr, RLT_OFF_IRQ_STAT);
  assign wr_mask   = reg_wr_stb && reg_hit(reg_addr, RLT_OFF_IRQ_MASK);
  assign rd_cnt_lo = reg_rd_stb && reg_hit(reg_addr, RLT_OFF_CNT_LO);

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  assign tk.run = run_q;
  assign tk.sel = ps_q;

  rlt_prescaler #(
    .PS_W (PS_W)
  ) u_prescaler (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .tk      (tk)
  );

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ps_q  <= RLT_RST_BYTE[PS_W-1:0];
      run_q <= RLT_RST_BYTE[RLT_CTRL_RUN_BIT];
    end else if (wr_ctrl) begin
      ps_q  <= reg_wr_data[RLT_CTRL_PS_LSB +: PS_W];
      run_q <= reg_wr_data[RLT_CTRL_RUN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Reload bytes
  // ----------------------------------------------------------------
  // Writes while running are still taken; the result is merely flagged
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      reload_lo_q <= RLT_RST_BYTE;
    end else if (wr_rlo) begin
      reload_lo_q <= reg_wr_data;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      reload_hi_q <= RLT_RST_BYTE;
    end else if (wr_rhi) begin
      reload_hi_q <= reg_wr_data;
    end
  end

  assign reload_w = {reload_hi_q, reload_lo_q};

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  assign rollover = tk.tick && (cnt_q == {CNT_W{1'b1}});

  always_comb begin
    cnt_d = cnt_q;
    if (rollover) begin
      cnt_d = reload_w[CNT_W-1:0];
    end else if (tk.tick) begin
      cnt_d = cnt_q + CNT_W'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign cnt_w = rlt_word_t'(cnt_q);

  // Reading the low byte freezes the high byte for a coherent pair
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_hi_snap_q <= RLT_RST_BYTE;
    end else if (rd_cnt_lo) begin
      cnt_hi_snap_q <= cnt_w[2*RLT_DATA_W-1:RLT_DATA_W];
    end
  end

  // ----------------------------------------------------------------
  // Overflow flag
  // ----------------------------------------------------------------
  // Hardware set wins over every clear arriving in the same cycle
  always_comb begin
    ovf_d = ovf_q;
    if (rollover) begin
      ovf_d = 1'b1;
    end else if (wr_ctrl) begin
      ovf_d = reg_wr_data[RLT_CTRL_OVF_BIT];
    end else if (wr_stat && reg_wr_data[RLT_IRQ_OVF_BIT]) begin
      ovf_d = 1'b0;
    end else if (isr_enter) begin
      ovf_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ovf_q <= RLT_RST_BYTE[RLT_CTRL_OVF_BIT];
    end else begin
      ovf_q <= ovf_d;
    end
  end

  // ----------------------------------------------------------------
  // Reload written while running
  // ----------------------------------------------------------------
  always_comb begin
    misuse_d = misuse_q;
    if ((wr_rlo || wr_rhi) && run_q) begin
      misuse_d = 1'b1;
    end else if (wr_stat && reg_wr_data[RLT_IRQ_MIS_BIT]) begin
      misuse_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      misuse_q <= 1'b0;
    end else begin
      misuse_q <= misuse_d;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt mask and output
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      mask_q <= RLT_RST_IRQ;
    end else if (wr_mask) begin
      mask_q <= reg_wr_data[RLT_IRQ_W-1:0];
    end
  end

  // One cycle behind the flag so the output stays a plain flop
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= (ovf_q && mask_q[RLT_IRQ_OVF_BIT]) ||
               (misuse_q && mask_q[RLT_IRQ_MIS_BIT]);
    end
  end

  assign irq = irq_q;

  // ----------------------------------------------------------------
  // Baud clock source
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      baud_q <= 1'b0;
    end else begin
      baud_q <= rollover;
    end
  end

  assign baud_tick = baud_q;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_view = RLT_RST_BYTE;
    ctrl_view[RLT_CTRL_PS_LSB +: PS_W] = ps_q;
    ctrl_view[RLT_CTRL_RUN_BIT] = run_q;
    ctrl_view[RLT_CTRL_OVF_BIT] = ovf_q;
    stat_view = RLT_RST_BYTE;
    stat_view[RLT_IRQ_OVF_BIT] = ovf_q;
    stat_view[RLT_IRQ_MIS_BIT] = misuse_q;
    mask_view = RLT_RST_BYTE;
    mask_view[RLT_IRQ_W-1:0] = mask_q;
  end

  always_comb begin
    case (reg_addr)
      RLT_OFF_CTRL: begin
        rd_mux = ctrl_view;
      end
      RLT_OFF_RELOAD_LO: begin
        rd_mux = reload_lo_q;
      end
      RLT_OFF_RELOAD_HI: begin
        rd_mux = reload_hi_q;
      end
      RLT_OFF_IRQ_STAT: begin
        rd_mux = stat_view;
      end
      RLT_OFF_IRQ_MASK: begin
        rd_mux = mask_view;
      end
      RLT_OFF_CNT_LO: begin
        rd_mux = cnt_w[RLT_DATA_W-1:0];
      end
      RLT_OFF_CNT_HI: begin
        rd_mux = cnt_hi_snap_q;
      end
      default: begin
        rd_mux = RLT_RST_BYTE;
      end
    endcase
  end

  // Data stand only in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data_q <= RLT_RST_BYTE;
    end else if (reg_rd_stb) begin
      rd_data_q <= rd_mux;
    end else begin
      rd_data_q <= RLT_RST_BYTE;
    end
  end

  assign reg_rd_data = rd_data_q;

endmodule

//--- shared/rlt_pkg.sv
// Purpose: Shared constants and types of the reload timer
// Assumes: Byte-wide register port, 8-bit register addresses
// Notes:   Every offset and field position lives here, with the reset values of the control, reload and mask registers
package rlt_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int RLT_CNT_W  = 16;
  localparam int RLT_PS_W   = 3;
  localparam int RLT_ADDR_W = 8;
  localparam int RLT_DATA_W = 8;
  localparam int RLT_IRQ_W  = 2;

  typedef logic [RLT_ADDR_W-1:0]   rlt_addr_t;
  typedef logic [RLT_DATA_W-1:0]   rlt_byte_t;
  typedef logic [2*RLT_DATA_W-1:0] rlt_word_t;
  typedef logic [RLT_IRQ_W-1:0]    rlt_irq_t;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam rlt_addr_t RLT_OFF_CTRL      = 8'hc4;
  localparam rlt_addr_t RLT_OFF_RELOAD_LO = 8'hc5;
  localparam rlt_addr_t RLT_OFF_RELOAD_HI = 8'hc6;
  localparam rlt_addr_t RLT_OFF_IRQ_STAT  = 8'hc8;
  localparam rlt_addr_t RLT_OFF_IRQ_MASK  = 8'hc9;
  localparam rlt_addr_t RLT_OFF_CNT_LO    = 8'hca;
  localparam rlt_addr_t RLT_OFF_CNT_HI    = 8'hcb;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int RLT_CTRL_PS_LSB  = 0;
  localparam int RLT_CTRL_RUN_BIT = 3;
  localparam int RLT_CTRL_OVF_BIT = 4;
  localparam int RLT_IRQ_OVF_BIT  = 0;
  localparam int RLT_IRQ_MIS_BIT  = 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam rlt_byte_t RLT_RST_BYTE = 8'h00;
  localparam rlt_irq_t  RLT_RST_IRQ  = 2'h0;

endpackage

//--- shared/rlt_tick_if.sv
// Purpose: Carries run, prescale select and tick between timer and divider
// Assumes: Same clock on both ends
// Notes:   Tick is a one-cycle enable, never a clock
`timescale 1ns/1ns
interface rlt_tick_if #(
  parameter int PS_W = 3
);
  logic            run;
  logic [PS_W-1:0] sel;
  logic            tick;

  modport ctl (output run, output sel, input tick);
  modport div (input run, input sel, output tick);
endinterface

//--- logic/rlt_prescaler.sv
// Purpose: Power-of-two prescaler making the counting enable
// Assumes: Select is stable while running
// Notes:   Cleared while halted so a restart waits one full period
`timescale 1ns/1ns
module rlt_prescaler #(
  parameter int PS_W = 3
) (
  // Clock and reset
  input wire logic   ref_clk,
  input wire logic   arst_n,
  // Tick channel
  rlt_tick_if.div    tk
);

  localparam int DIV_W = (1 << PS_W) - 1;

  if (PS_W < 1 || PS_W > 4) begin : g_bad_ps
    $error("Prescale select width out of range");
  end

  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] sel_mask;

  // Low sel bits of the divider all ones marks the end of a period
  function automatic logic [DIV_W-1:0] ps_mask(input logic [PS_W-1:0] s);
    logic [DIV_W-1:0] m;
    m = '0;
    for (int i = 0; i < DIV_W; i++) begin
      m[i] = (i < int'(s));
    end
    return m;
  endfunction

  assign sel_mask = ps_mask(tk.sel);
  assign tk.tick  = tk.run && ((div_q & sel_mask) == sel_mask);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_q <= '0;
    end else if (!tk.run) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + DIV_W'(1);
    end
  end

endmodule

//--- testbench/rlt_top_chk.sv
// Purpose: Concurrent checks on the reload timer top ports
// Assumes: Single ref_clk domain, arst_n active low
// Notes:   Mask and run are shadowed from register writes seen at the port
`timescale 1ns/1ns
module rlt_top_chk
  import rlt_pkg::*;
#(
  parameter int CNT_W = rlt_pkg::RLT_CNT_W,
  parameter int PS_W  = rlt_pkg::RLT_PS_W
) (
  // Clock and reset
  input wire logic               ref_clk,
  input wire logic               arst_n,
  // Register port
  input wire rlt_pkg::rlt_addr_t reg_addr,
  input wire rlt_pkg::rlt_byte_t reg_wr_data,
  input wire logic               reg_wr_stb,
  input wire logic               reg_rd_stb,
  input wire rlt_pkg::rlt_byte_t reg_rd_data,
  // Processor and serial side
  input wire logic               isr_enter,
  input wire logic               irq,
  input wire logic               baud_tick
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  // ----------------------------------------------------------------
  // Shadow state
  // ----------------------------------------------------------------
  logic [1:0] mask_q;
  logic       run_q;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      mask_q <= 2'h0;
    end else if (reg_wr_stb && reg_addr == RLT_OFF_IRQ_MASK) begin
      mask_q <= reg_wr_data[1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      run_q <= 1'b0;
    end else if (reg_wr_stb && reg_addr == RLT_OFF_CTRL) begin
      run_q <= reg_wr_data[RLT_CTRL_RUN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_rd_idle;
    !$past(reg_rd_stb) |-> reg_rd_data == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");

  property p_unmapped;
    reg_rd_stb && reg_addr < RLT_OFF_CTRL |=> reg_rd_data == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  property p_ctrl_hi;
    reg_rd_stb && reg_addr == RLT_OFF_CTRL |=> reg_rd_data[7:5] == 3'h0;
  endproperty
  a_ctrl_hi: assert property (p_ctrl_hi) else $error("control upper bits set");

  sequence s_ctrl_wrrd;
    reg_wr_stb && reg_addr == RLT_OFF_CTRL && !reg_wr_data[RLT_CTRL_RUN_BIT]
      ##1 reg_rd_stb && reg_addr == RLT_OFF_CTRL;
  endsequence
  property p_ctrl_wr;
    s_ctrl_wrrd |=> reg_rd_data[3:0] == $past(reg_wr_data[3:0], 2);
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr) else $error("control readback wrong");

  property p_rel_rd;
    reg_wr_stb && reg_addr == RLT_OFF_RELOAD_HI ##1 reg_rd_stb && reg_addr == RLT_OFF_RELOAD_HI
      |=> reg_rd_data == $past(reg_wr_data, 2);
  endproperty
  a_rel_rd: assert property (p_rel_rd) else $error("reload readback wrong");

  property p_isr_clr;
    isr_enter ##1 !baud_tick |=> !irq;
  endproperty
  a_isr_clr: assert property (p_isr_clr) else $error("irq kept after service entry");

  property p_irq_on;
    baud_tick && mask_q[0] |=> irq;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("irq missing on overflow");

  property p_irq_off;
    !$past(|mask_q) |-> !irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq while masked");

  property p_halt;
    !$past(run_q) |-> !baud_tick;
  endproperty
  a_halt: assert property (p_halt) else $error("overflow while halted");

  c_baud: cover property (baud_tick);
  c_irq:  cover property ($rose(irq));
  c_isr:  cover property (isr_enter && irq);
  c_wrrd: cover property (s_ctrl_wrrd);
endmodule

bind rlt_top rlt_top_chk #(.CNT_W(CNT_W), .PS_W(PS_W)) rlt_top_chk_i (.ref_clk(ref_clk), .arst_n(arst_n),
  .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_wr_stb(reg_wr_stb), .reg_rd_stb(reg_rd_stb),
  .reg_rd_data(reg_rd_data), .isr_enter(isr_enter), .irq(irq), .baud_tick(baud_tick));

//--- testbench/reload_timer_16bit_test.sv
// Purpose: Self-checking bench for the reload timer
// Assumes: One full count from zero is needed before reloads start
// Notes:   Periods are measured on baud_tick and compared with the model
`timescale 1ns/1ns
module reload_timer_16bit_test;
  import rlt_pkg::*;
  // First full count is 65536 cycles, the prescaled loop at most about 16k more
  localparam int CEIL = 90000;

  logic        ref_clk;
  logic        arst_n;
  rlt_addr_t   reg_addr;
  rlt_byte_t   reg_wr_data;
  logic        reg_wr_stb;
  logic        reg_rd_stb;
  rlt_byte_t   reg_rd_data;
  logic        isr_enter;
  logic        irq;
  logic        baud_tick;
  rlt_byte_t   rdv;
  rlt_byte_t   rdw;
  logic [31:0] lfsr;
  int          err_total;
  int          samples_checked;
  int          cyc;
  int          n;
  int          m_lo;
  rlt_addr_t   rst_q[$] = '{8'hc4, 8'hc5, 8'hc6, 8'hc8, 8'hc9, 8'hca, 8'hcb, 8'h00};

  rlt_top #(.CNT_W(16), .PS_W(3)) rlt_top_i (.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wr_data(reg_wr_data), .reg_wr_stb(reg_wr_stb), .reg_rd_stb(reg_rd_stb), .reg_rd_data(reg_rd_data),
    .isr_enter(isr_enter), .irq(irq), .baud_tick(baud_tick));

  // ----------------------------------------------------------------
  // Clock, timeout and helpers
  // ----------------------------------------------------------------
  always #10 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == CEIL) begin
      err_total++;
      final_report();
    end
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic final_report;
    $display("checks=%0d errors=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk_b(input rlt_byte_t got, input rlt_byte_t exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_n(input int got, input int exp);
    samples_checked++;
    if (got != exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Bus tasks start just after a rising edge and end on one
  task automatic wr(input rlt_addr_t a, input rlt_byte_t d);
    reg_wr_stb  <= 1'b1;
    reg_addr    <= a;
    reg_wr_data <= d;
    @(posedge ref_clk);
    reg_wr_stb  <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd(input rlt_addr_t a, output rlt_byte_t d);
    reg_rd_stb <= 1'b1;
    reg_addr   <= a;
    @(posedge ref_clk);
    reg_rd_stb <= 1'b0;
    @(negedge ref_clk);
    d = reg_rd_data;
    @(posedge ref_clk);
  endtask

  // Write then read with no gap, so stale read paths show up
  task automatic wrrd(input rlt_addr_t a, input rlt_byte_t dw, output rlt_byte_t d);
    reg_wr_stb  <= 1'b1;
    reg_addr    <= a;
    reg_wr_data <= dw;
    @(posedge ref_clk);
    reg_wr_stb  <= 1'b0;
    reg_rd_stb  <= 1'b1;
    @(posedge ref_clk);
    reg_rd_stb  <= 1'b0;
    @(negedge ref_clk);
    d = reg_rd_data;
    @(posedge ref_clk);
  endtask

  task automatic chk_irq(input rlt_byte_t exp);
    @(negedge ref_clk);
    chk_b({7'h0, irq}, exp);
    @(posedge ref_clk);
  endtask

  task automatic wait_baud(input int lim, output int cnt);
    cnt = 1;
    @(negedge ref_clk);
    while (baud_tick !== 1'b1 && cnt < lim) begin
      @(negedge ref_clk);
      cnt++;
    end
    if (cnt >= lim) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, cnt, lim);
    end
    @(posedge ref_clk);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    arst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wr_data = 8'h00;
    reg_wr_stb = 1'b0;
    reg_rd_stb = 1'b0;
    isr_enter = 1'b0;
    lfsr = 32'h204c4e82;
    err_total = 0;
    samples_checked = 0;
    cyc = 0;
    repeat (12) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    foreach (rst_q[i]) begin
      rd(rst_q[i], rdv);
      chk_b(rdv, 8'h00);
    end
    wr(8'hc7, 8'h5a);
    rd(8'hc7, rdv);
    chk_b(rdv, 8'h00);
    wrrd(RLT_OFF_RELOAD_HI, 8'hff, rdv);
    chk_b(rdv, 8'hff);
    wrrd(RLT_OFF_CTRL, 8'hf7, rdv);
    chk_b(rdv, 8'h17);
    chk_irq(8'h00);
    wr(RLT_OFF_IRQ_MASK, 8'h01);
    chk_irq(8'h01);
    wr(RLT_OFF_IRQ_STAT, 8'h01);
    chk_irq(8'h00);
    wrrd(RLT_OFF_CTRL, 8'h00, rdv);
    chk_b(rdv, 8'h00);
    // First full count from zero, then reloads
    wr(RLT_OFF_RELOAD_LO, 8'hf0);
    wr(RLT_OFF_CTRL, 8'h08);
    wait_baud(70000, n);
    chk_n(n, 1 << RLT_CNT_W);
    chk_irq(8'h01);
    wr(RLT_OFF_CTRL, 8'h10);
    rd(RLT_OFF_IRQ_STAT, rdv);
    chk_b(rdv, 8'h01);
    isr_enter <= 1'b1;
    @(posedge ref_clk);
    isr_enter <= 1'b0;
    @(posedge ref_clk);
    chk_irq(8'h00);
    rd(RLT_OFF_CNT_LO, rdv);
    rd(RLT_OFF_CNT_HI, rdw);
    chk_b(rdw, 8'hff);
    repeat (40) @(posedge ref_clk);
    rd(RLT_OFF_CNT_LO, rdw);
    chk_b(rdw, rdv);
    for (int s = 0; s < 8; s++) begin
      lfsr = lfsr_next(lfsr);
      m_lo = 224 + int'(lfsr[4:0]);
      wr(RLT_OFF_RELOAD_LO, rlt_byte_t'(m_lo));
      wr(RLT_OFF_CTRL, rlt_byte_t'(8 + s));
      wait_baud(8192, n);
      wait_baud(8192, n);
      chk_n(n, (256 - m_lo) << s);
      rd(RLT_OFF_CTRL, rdv);
      chk_b(rdv, rlt_byte_t'(24 + s));
      wr(RLT_OFF_CTRL, 8'h00);
    end
    // Reload written on purpose while running, to reach the misuse status
    wr(RLT_OFF_CTRL, 8'h08);
    wr(RLT_OFF_RELOAD_LO, 8'hf8);
    wr(RLT_OFF_IRQ_MASK, 8'h02);
    chk_irq(8'h01);
    wr(RLT_OFF_CTRL, 8'h00);
    rd(RLT_OFF_IRQ_STAT, rdv);
    chk_b(rdv & 8'h02, 8'h02);
    wr(RLT_OFF_IRQ_STAT, 8'h02);
    chk_irq(8'h00);
    rd(RLT_OFF_IRQ_STAT, rdv);
    chk_b(rdv & 8'h02, 8'h00);
    // Reset in mid-run must bring every register back to zero
    wr(RLT_OFF_CTRL, 8'h1f);
    arst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    foreach (rst_q[i]) begin
      rd(rst_q[i], rdv);
      chk_b(rdv, 8'h00);
    end
    chk_irq(8'h00);
    final_report();
  end
endmodule
